// [hdl/shs_map.svh]
/*
 * Constants of the homing sequencer: register offsets, field positions,
 * reset values, setting limits and trip codes.
 * Assumes inclusion by bare name from the design.
 */
`ifndef SHS_MAP_SVH
`define SHS_MAP_SVH

// ----------------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------------
`define SHS_OFS_CTRL       4'h0
`define SHS_OFS_STATUS     4'h1
`define SHS_OFS_FAST_SPD   4'h2
`define SHS_OFS_SLOW_SPD   4'h3
`define SHS_OFS_OFFS_SPD   4'h4
`define SHS_OFS_ACCEL      4'h5
`define SHS_OFS_DECEL      4'h6
`define SHS_OFS_MODE       4'h7
`define SHS_OFS_ZCOUNT     4'h8
`define SHS_OFS_HOME_OFS   4'h9
`define SHS_OFS_ERRCODE    4'ha

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SHS_CTRL_START     0
`define SHS_CTRL_CLEAR     1
`define SHS_MODE_DIR       0
`define SHS_MODE_TYPE_LO   4
`define SHS_MODE_OFS_EN    8
`define SHS_MODE_OT_LO     12

// ----------------------------------------------------------------------
// Limits, reset values and codes
// ----------------------------------------------------------------------
`define SHS_SPEED_MAX      13'h1770
`define SHS_ACCEL_MAX      12'hbb8
`define SHS_TYPE_REAR_Z    3'h2
`define SHS_TYPE_LIMIT_Z   3'h3
`define SHS_ERR_HOMING     8'h44
`define SHS_ERR_BADTYPE    8'hff
`define SHS_RST_SPEED      13'h0000
`define SHS_RST_ACCEL      12'h000
`define SHS_RST_ZCOUNT     8'h01

`endif

// [hdl/shs_pkg.sv]
/*
 * Types of the homing sequencer: sensor pin bundle, motion command and
 * sequencer states.
 * Assumes shs_map.svh sits beside it.
 */
package shs_pkg;

   // Raw sensor pins, all asynchronous to i_clk
   typedef struct packed {
      logic home;
      logic lim_pos;
      logic lim_neg;
      logic zph;
      logic enc;
   } shs_pins_t;

   // Command to the speed loop
   typedef struct packed {
      logic        run;
      logic        dir;
      logic        quick_stop;
      logic [12:0] speed;
      logic [11:0] accel;
      logic [11:0] decel;
   } shs_cmd_t;

   typedef enum logic [3:0] {
      ST_IDLE, ST_CHECK, ST_FAST_SEEK, ST_REV_STOP, ST_REV_SEEK, ST_REV_TURN,
      ST_SLOW_OFF, ST_Z_COUNT, ST_LIM_SEEK, ST_LIM_STOP, ST_LIM_OFF,
      ST_OFFSET, ST_DONE, ST_ERR
   } shs_state_t;

endpackage : shs_pkg

// [hdl/shs_homing.sv]
/*
 * Homing sequencer: drives a speed loop toward home from home sensor,
 * limit sensors and encoder index, with settings over a plain register port.
 * Assumes a speed loop on i_clk that ramps o_cmd and reports standstill.
 */
`timescale 1ns/1ps
`include "shs_map.svh"

module shs_homing (
   input  wire logic                i_clk,
   input  wire logic                i_rst,
   input  wire logic [3:0]          i_addr,
   input  wire logic [31:0]         i_wdata,
   input  wire logic                i_wr,
   input  wire logic                i_rd,
   output logic      [31:0]         o_rdata,
   input  wire shs_pkg::shs_pins_t  i_pins,
   input  wire logic                i_stopped,
   output shs_pkg::shs_cmd_t        o_cmd,
   output logic                     o_home_pulse,
   output logic                     o_busy,
   output logic                     o_alarm
);
   import shs_pkg::*;

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [12:0] fast_r, slow_r, offs_spd_r;
   logic [11:0] accel_r, decel_r;
   logic        dir_r, ofs_en_r, done_r;
   logic [2:0]  type_r;
   logic [1:0]  ot_r;
   logic [7:0]  zcount_r, zcnt_r, err_r;
   logic [31:0] home_ofs_r, ofs_cnt_r, ofs_abs;
   logic [31:0] rdata_r;
   shs_pins_t   sync1_r, sync2_r, prev_r;
   shs_state_t  state_r, state_nxt;
   shs_cmd_t    cmd_r;
   logic        home_pulse_r, seen_on_r;
   logic        start, clear, settings_zero, lim_ahead, lim_behind, move_dir;
   logic        home_rise, home_fall, z_rise, enc_rise, behind_fall, z_last;
   logic [7:0]  z_target;

   // Saturate a speed write at its top value
   function automatic logic [12:0] sat_speed(input logic [31:0] v);
      sat_speed = (v > 32'(`SHS_SPEED_MAX)) ? `SHS_SPEED_MAX : v[12:0];
   endfunction : sat_speed

   // Saturate a ramp write at its top value
   function automatic logic [11:0] sat_accel(input logic [31:0] v);
      sat_accel = (v > 32'(`SHS_ACCEL_MAX)) ? `SHS_ACCEL_MAX : v[11:0];
   endfunction : sat_accel

   // ----------------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------------
   assign start = i_wr && (i_addr == `SHS_OFS_CTRL) && i_wdata[`SHS_CTRL_START];
   assign clear = i_wr && (i_addr == `SHS_OFS_CTRL) && i_wdata[`SHS_CTRL_CLEAR];

   // Setting registers, speed and ramp writes clamped to their ranges
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         fast_r     <= `SHS_RST_SPEED;
         slow_r     <= `SHS_RST_SPEED;
         offs_spd_r <= `SHS_RST_SPEED;
         accel_r    <= `SHS_RST_ACCEL;
         decel_r    <= `SHS_RST_ACCEL;
         dir_r      <= 1'b0;
         type_r     <= `SHS_TYPE_REAR_Z;
         ofs_en_r   <= 1'b0;
         ot_r       <= 2'h0;
         zcount_r   <= `SHS_RST_ZCOUNT;
         home_ofs_r <= 32'h0000_0000;
      end else if (i_wr) begin
         unique case (i_addr)
            `SHS_OFS_FAST_SPD: fast_r     <= sat_speed(i_wdata);
            `SHS_OFS_SLOW_SPD: slow_r     <= sat_speed(i_wdata);
            `SHS_OFS_OFFS_SPD: offs_spd_r <= sat_speed(i_wdata);
            `SHS_OFS_ACCEL:    accel_r    <= sat_accel(i_wdata);
            `SHS_OFS_DECEL:    decel_r    <= sat_accel(i_wdata);
            `SHS_OFS_MODE: begin
               dir_r    <= i_wdata[`SHS_MODE_DIR];
               type_r   <= i_wdata[`SHS_MODE_TYPE_LO +: 3];
               ofs_en_r <= i_wdata[`SHS_MODE_OFS_EN];
               ot_r     <= i_wdata[`SHS_MODE_OT_LO +: 2];
            end
            `SHS_OFS_ZCOUNT:   zcount_r   <= i_wdata[7:0];
            `SHS_OFS_HOME_OFS: home_ofs_r <= i_wdata;
            default: begin
            end
         endcase
      end
   end

   // Read data, valid only in the cycle after the strobe
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (i_rd) begin
         unique case (i_addr)
            `SHS_OFS_STATUS:   rdata_r <= {16'h0000, zcnt_r, 4'(state_r), 1'b0, (state_r == ST_ERR), done_r, o_busy};
            `SHS_OFS_FAST_SPD: rdata_r <= {19'h0, fast_r};
            `SHS_OFS_SLOW_SPD: rdata_r <= {19'h0, slow_r};
            `SHS_OFS_OFFS_SPD: rdata_r <= {19'h0, offs_spd_r};
            `SHS_OFS_ACCEL:    rdata_r <= {20'h0, accel_r};
            `SHS_OFS_DECEL:    rdata_r <= {20'h0, decel_r};
            `SHS_OFS_MODE:     rdata_r <= {18'h0, ot_r, 3'h0, ofs_en_r, 1'b0, type_r, 3'h0, dir_r};
            `SHS_OFS_ZCOUNT:   rdata_r <= {24'h0, zcount_r};
            `SHS_OFS_HOME_OFS: rdata_r <= home_ofs_r;
            `SHS_OFS_ERRCODE:  rdata_r <= {24'h0, err_r};
            default:           rdata_r <= 32'h0000_0000;
         endcase
      end else begin
         rdata_r <= 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------------
   // Sensor inputs
   // ----------------------------------------------------------------------
   // Two-stage synchronisers, then one more stage for edges
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r  <= '0;
      end else begin
         sync1_r <= i_pins;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   assign home_rise   = sync2_r.home && !prev_r.home;
   assign home_fall   = !sync2_r.home && prev_r.home;
   assign z_rise      = sync2_r.zph && !prev_r.zph;
   assign enc_rise    = sync2_r.enc && !prev_r.enc;
   // Travel direction of the current state; o_cmd lags a cycle, and at a
   // reversal it would still point at the limit just left, a false trip
   always_comb begin
      move_dir = dir_r;
      if (state_r == ST_REV_SEEK || state_r == ST_REV_TURN ||
          state_r == ST_LIM_SEEK || state_r == ST_LIM_STOP) begin
         move_dir = !dir_r;
      end else if (state_r == ST_OFFSET) begin
         move_dir = home_ofs_r[31];
      end
   end

   // Limits ahead of and behind the travel of the current state
   assign lim_ahead   = move_dir ? sync2_r.lim_neg : sync2_r.lim_pos;
   assign lim_behind  = move_dir ? sync2_r.lim_pos : sync2_r.lim_neg;
   assign behind_fall = !lim_behind && (move_dir ? prev_r.lim_pos : prev_r.lim_neg);

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   assign settings_zero = (fast_r == 13'h0) || (slow_r == 13'h0) ||
                          (accel_r == 12'h0) || (decel_r == 12'h0);
   assign z_target = (zcount_r == 8'h00) ? 8'h01 : zcount_r;
   assign z_last   = z_rise && ((zcnt_r + 8'h01) >= z_target);
   assign ofs_abs  = home_ofs_r[31] ? (~home_ofs_r + 32'h1) : home_ofs_r;

   // Next state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: if (start) state_nxt = ST_CHECK;
         ST_CHECK: begin
            if (settings_zero) state_nxt = ST_ERR;
            else if (type_r == `SHS_TYPE_REAR_Z) state_nxt = ST_FAST_SEEK;
            else if (type_r == `SHS_TYPE_LIMIT_Z) state_nxt = ST_LIM_SEEK;
            else state_nxt = ST_ERR;
         end
         ST_FAST_SEEK: begin
            if (home_rise) state_nxt = ST_SLOW_OFF;
            else if (lim_ahead) state_nxt = ST_REV_STOP;
         end
         ST_REV_STOP: if (i_stopped) state_nxt = ST_REV_SEEK;
         ST_REV_SEEK: begin
            if (home_fall && seen_on_r) state_nxt = ST_REV_TURN;
            else if (lim_ahead) state_nxt = ST_ERR;
         end
         ST_REV_TURN: if (i_stopped) state_nxt = ST_FAST_SEEK;
         ST_SLOW_OFF: begin
            if (lim_ahead) state_nxt = ST_ERR;
            else if (home_fall) state_nxt = ST_Z_COUNT;
         end
         ST_Z_COUNT: begin
            if (lim_ahead) state_nxt = ST_ERR;
            else if (z_last) state_nxt = ofs_en_r ? ST_OFFSET : ST_DONE;
         end
         ST_LIM_SEEK: if (lim_ahead) state_nxt = ST_LIM_STOP;
         ST_LIM_STOP: if (i_stopped) state_nxt = ST_LIM_OFF;
         ST_LIM_OFF: if (behind_fall) state_nxt = ST_Z_COUNT;
         ST_OFFSET: begin
            if (ofs_cnt_r >= ofs_abs) state_nxt = ST_DONE;
         end
         ST_DONE: state_nxt = ST_IDLE;
         ST_ERR: if (clear) state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
      if (clear && state_r != ST_ERR) state_nxt = ST_IDLE;
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (i_rst) state_r <= ST_IDLE;
      else       state_r <= state_nxt;
   end

   // Home sensor seen during the reversed search
   always_ff @(posedge i_clk) begin
      if (i_rst) seen_on_r <= 1'b0;
      else if (state_r != ST_REV_SEEK) seen_on_r <= 1'b0;
      else if (sync2_r.home) seen_on_r <= 1'b1;
   end

   // Index pulse counter
   always_ff @(posedge i_clk) begin
      if (i_rst) zcnt_r <= 8'h00;
      else if (state_r == ST_CHECK) zcnt_r <= 8'h00;
      else if (state_r == ST_Z_COUNT && z_rise) zcnt_r <= zcnt_r + 8'h01;
   end

   // Encoder pulses travelled during the offset move
   always_ff @(posedge i_clk) begin
      if (i_rst) ofs_cnt_r <= 32'h0;
      else if (state_r != ST_OFFSET) ofs_cnt_r <= 32'h0;
      else if (enc_rise) ofs_cnt_r <= ofs_cnt_r + 32'h1;
   end

   // Trip code, done flag and home pulse
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         err_r        <= 8'h00;
         done_r       <= 1'b0;
         home_pulse_r <= 1'b0;
      end else begin
         home_pulse_r <= (state_r == ST_Z_COUNT) && (state_nxt == ST_OFFSET || state_nxt == ST_DONE);
         if (state_nxt == ST_ERR && state_r != ST_ERR) begin
            err_r <= (state_r == ST_CHECK && !settings_zero) ? `SHS_ERR_BADTYPE : `SHS_ERR_HOMING;
         end else if (start && state_r == ST_IDLE) begin
            err_r <= 8'h00;
         end
         if (state_r == ST_DONE) done_r <= 1'b1;
         else if (start && state_r == ST_IDLE) done_r <= 1'b0;
      end
   end

   // Motion command, one cycle behind the state
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cmd_r <= '0;
      end else begin
         cmd_r.accel      <= accel_r;
         cmd_r.decel      <= decel_r;
         cmd_r.quick_stop <= 1'b0;
         cmd_r.run        <= 1'b1;
         cmd_r.dir        <= dir_r;
         cmd_r.speed      <= 13'h0;
         unique case (state_r)
            ST_FAST_SEEK: cmd_r.speed <= fast_r;
            ST_REV_STOP: begin
               cmd_r.run        <= 1'b0;
               cmd_r.quick_stop <= ot_r[0];
            end
            ST_REV_SEEK: begin
               cmd_r.speed <= fast_r;
               cmd_r.dir   <= !dir_r;
            end
            ST_REV_TURN: begin
               cmd_r.run <= 1'b0;
               cmd_r.dir <= !dir_r;
            end
            ST_SLOW_OFF, ST_Z_COUNT, ST_LIM_OFF: cmd_r.speed <= slow_r;
            ST_LIM_SEEK: begin
               cmd_r.speed <= fast_r;
               cmd_r.dir   <= !dir_r;
            end
            ST_LIM_STOP: begin
               cmd_r.run        <= 1'b0;
               cmd_r.dir        <= !dir_r;
               cmd_r.quick_stop <= ot_r[0];
            end
            ST_OFFSET: begin
               cmd_r.speed <= offs_spd_r;
               cmd_r.dir   <= home_ofs_r[31];
            end
            ST_ERR: begin
               cmd_r.run        <= 1'b0;
               cmd_r.quick_stop <= ot_r[0];
            end
            default: cmd_r.run <= 1'b0;
         endcase
      end
   end

   assign o_cmd        = cmd_r;
   assign o_rdata      = rdata_r;
   assign o_home_pulse = home_pulse_r;
   assign o_busy       = (state_r != ST_IDLE) && (state_r != ST_ERR);
   assign o_alarm      = (state_r == ST_ERR);

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   zero_trip_a: assert property (state_r == ST_CHECK && settings_zero |=> o_alarm ##1 err_r == 8'h44)
      else $error("zero setting did not trip");
   type_rear_a: assert property (state_r == ST_CHECK && !settings_zero && type_r == 3'h2 |=> state_r == ST_FAST_SEEK)
      else $error("type 2 not taken");
   type_limit_a: assert property (state_r == ST_CHECK && !settings_zero && type_r == 3'h3 |=> state_r == ST_LIM_SEEK)
      else $error("type 3 not taken");
   fast_seek_a: assert property (state_r == ST_FAST_SEEK |=> o_cmd.run && o_cmd.speed == $past(fast_r) && o_cmd.dir == $past(dir_r))
      else $error("fast seek command wrong");
   limit_seek_a: assert property (state_r == ST_LIM_SEEK |=> o_cmd.dir != $past(dir_r) && o_cmd.speed == $past(fast_r))
      else $error("limit seek command wrong");
   speed_range_a: assert property (fast_r <= 13'h1770 && slow_r <= 13'h1770 && offs_spd_r <= 13'h1770)
      else $error("speed setting out of range");
   ramp_range_a: assert property (accel_r <= 12'hbb8 && decel_r <= 12'hbb8)
      else $error("ramp setting out of range");
   rev_trip_a: assert property (state_r == ST_REV_SEEK && lim_ahead && !(home_fall && seen_on_r) |=> o_alarm)
      else $error("opposite limit did not trip");
   slow_trip_a: assert property (state_r == ST_SLOW_OFF && lim_ahead |=> o_alarm)
      else $error("limit during sensor-off wait did not trip");
   zcount_trip_a: assert property (state_r == ST_Z_COUNT && lim_ahead |=> o_alarm ##1 !o_cmd.run)
      else $error("limit during index count did not trip");
   stop_mode_a: assert property (state_r == ST_LIM_STOP |=> !o_cmd.run && o_cmd.quick_stop == $past(ot_r[0]))
      else $error("stop mode ignores over-travel setting");
   home_mark_a: assert property (state_r == ST_Z_COUNT && !lim_ahead && !clear && z_last |=> o_home_pulse && zcnt_r == $past(z_target))
      else $error("home not marked on target index");
   offset_go_a: assert property (state_r == ST_Z_COUNT && !lim_ahead && !clear && z_last && ofs_en_r |=> state_r == ST_OFFSET)
      else $error("offset move skipped");

   // Reversal, slow approach and refused homing types
   rev_dir_a: assert property (state_r == ST_REV_SEEK |=> o_cmd.run && o_cmd.dir != $past(dir_r))
      else $error("reversed search not reversed");
   slow_cmd_a: assert property (state_r == ST_Z_COUNT |=> o_cmd.speed == $past(slow_r))
      else $error("index count not at slow speed");
   bad_type_a: assert property (
      state_r == ST_CHECK && !settings_zero && !clear && !(type_r inside {3'h2, 3'h3}) |=> o_alarm)
      else $error("unsupported type not refused");

   rear_done_c: cover property (state_r == ST_Z_COUNT ##1 state_r == ST_DONE);
   limit_home_c: cover property (state_r == ST_LIM_OFF ##1 state_r == ST_Z_COUNT);
   reversal_c: cover property (state_r == ST_REV_TURN ##1 state_r == ST_FAST_SEEK);
   offset_done_c: cover property (state_r == ST_OFFSET ##1 state_r == ST_DONE);
   rev_trip_c: cover property (state_r == ST_REV_SEEK ##1 state_r == ST_ERR);

endmodule : shs_homing

// [sim/shs_motor_model.sv]
/*
 * Motor, encoder and sensor model on the far side of the homing sequencer.
 * Assumes shs_pkg is compiled first and the bench sets sensor positions.
 */
`timescale 1ns/1ps
module shs_motor_model (
   input  wire logic               i_clk,
   input  wire logic               i_rst,
   input  wire shs_pkg::shs_cmd_t  i_cmd,
   input  wire logic signed [15:0] i_home_lo,
   input  wire logic signed [15:0] i_home_hi,
   input  wire logic signed [15:0] i_lim_lo,
   input  wire logic signed [15:0] i_lim_hi,
   output shs_pkg::shs_pins_t      o_pins,
   output logic signed [15:0]      o_pos,
   output logic                    o_stopped
);
   import shs_pkg::*;
   logic [2:0] phase_r;
   logic [2:0] idle_r;
   logic       enc_r;
   // One step every eight cycles while running, one encoder pulse per step
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         phase_r <= 3'h0;
         o_pos   <= 16'sh0;
         enc_r   <= 1'b0;
      end else begin
         phase_r <= i_cmd.run ? phase_r + 3'h1 : 3'h0;
         enc_r   <= i_cmd.run && (phase_r == 3'h7);
         if (i_cmd.run && (phase_r == 3'h7)) begin
            o_pos <= i_cmd.dir ? o_pos - 16'sh1 : o_pos + 16'sh1;
         end
      end
   end
   // Standstill after a short ramp, at once on a quick stop
   always_ff @(posedge i_clk) begin
      if (i_rst || i_cmd.run) begin
         idle_r <= 3'h0;
      end else if (idle_r != 3'h7) begin
         idle_r <= idle_r + 3'h1;
      end
   end
   assign o_stopped = !i_cmd.run && (i_cmd.quick_stop || idle_r >= 3'h4);
   // Sensors follow position only, so they hold still while decelerating
   assign o_pins.home = (o_pos >= i_home_lo) && (o_pos <= i_home_hi);
   assign o_pins.lim_pos = (o_pos >= i_lim_hi);
   assign o_pins.lim_neg = (o_pos <= i_lim_lo);
   assign o_pins.zph = (o_pos[3:0] == 4'h0);
   assign o_pins.enc = enc_r;
endmodule : shs_motor_model

// [sim/test_shs_homing.sv]
/*
 * Self-checking bench of the homing sequencer with the motor model.
 * Assumes shs_pkg, shs_homing and shs_motor_model are compiled first.
 */
`timescale 1ns/1ps
module test_shs_homing;
   import shs_pkg::*;
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   logic               mrst = 1'b1;
   logic [3:0]         addr = 4'h0;
   logic [31:0]        wdata = 32'h0;
   logic               wr = 1'b0;
   logic               rd = 1'b0;
   logic [31:0]        rdata;
   shs_pins_t          pins;
   logic               stopped;
   shs_cmd_t           cmd;
   logic               hp, busy, alarm, seen = 1'b0, fdir, hdir;
   logic signed [15:0] hlo = 16'sh0, hhi = 16'sh0, llo = 16'sh0, lhi = 16'sh0, pos, hpos;
   logic [12:0]        fspd, hspd;
   logic [31:0]        d;
   int                 error_cnt = 0, checks_done = 0, cyc = 0;
   logic [3:0]  sat_a [5] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
   logic [31:0] sat_w [5] = '{32'h1b58, 32'h1771, 32'h1770, 32'hbb9, 32'h1388};
   logic [31:0] sat_e [5] = '{32'h1770, 32'h1770, 32'h1770, 32'hbb8, 32'hbb8};
   logic [3:0]  zad [4] = '{4'h2, 4'h3, 4'h5, 4'h6};
   logic [15:0] f_hl [3] = '{16'h28, 16'h28, 16'h3e8};
   logic [15:0] f_lh [3] = '{16'h37, 16'h46, 16'h32};
   logic [15:0] f_ll [3] = '{16'hff38, 16'hff38, 16'hffce};
   logic [15:0] f_pe [3] = '{16'h37, 16'h46, 16'hffce};

   shs_homing i_dut (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_pins(pins), .i_stopped(stopped), .o_cmd(cmd), .o_home_pulse(hp),
      .o_busy(busy), .o_alarm(alarm));
   shs_motor_model i_mot (.i_clk(clk), .i_rst(mrst), .i_cmd(cmd), .i_home_lo(hlo), .i_home_hi(hhi),
      .i_lim_lo(llo), .i_lim_hi(lhi), .o_pins(pins), .o_pos(pos), .o_stopped(stopped));

   // ----------------------------------------------------------------------
   // Clock, hang guard and capture of home and first motion
   // ----------------------------------------------------------------------
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt = error_cnt + 1;
         final_report();
      end
   end
   always @(posedge clk) begin
      if (hp === 1'b1) begin
         hpos <= pos;
         hspd <= cmd.speed;
         hdir <= cmd.dir;
      end
      if (mrst) begin
         seen <= 1'b0;
      end else if (cmd.run === 1'b1 && !seen) begin
         seen <= 1'b1;
         fspd <= cmd.speed;
         fdir <= cmd.dir;
      end
   end

   // ----------------------------------------------------------------------
   // Bus tasks and checks
   // ----------------------------------------------------------------------
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp_v);
      checks_done = checks_done + 1;
      if (seen_v !== exp_v) begin
         error_cnt = error_cnt + 1;
         $display("[FAIL] %s expected %h seen %h", nm, exp_v, seen_v);
      end
   endtask : chk
   task automatic setup(input logic [31:0] mode, input logic [31:0] zc, input logic [31:0] ofs,
                        input logic [15:0] hl, input logic [15:0] hh, input logic [15:0] ll,
                        input logic [15:0] lh);
      wr_reg(4'h0, 32'h2);
      wr_reg(4'h2, 32'h64);
      wr_reg(4'h3, 32'h14);
      wr_reg(4'h4, 32'h1e);
      wr_reg(4'h5, 32'h32);
      wr_reg(4'h6, 32'h32);
      wr_reg(4'h7, mode);
      wr_reg(4'h8, zc);
      wr_reg(4'h9, ofs);
      hlo  <= hl;
      hhi  <= hh;
      llo  <= ll;
      lhi  <= lh;
      mrst <= 1'b1;
      @(posedge clk);
      mrst <= 1'b0;
   endtask : setup
   task automatic go();
      int n;
      wr_reg(4'h0, 32'h1);
      repeat (3) @(posedge clk);
      n = 0;
      while (busy !== 1'b0 && n < 20000) begin
         @(posedge clk);
         n = n + 1;
      end
      if (n >= 20000) error_cnt = error_cnt + 1;
      #1;
   endtask : go
   task automatic final_report();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst  <= 1'b0;
      mrst <= 1'b0;
      rd_reg(4'h8, d);
      chk("zcount reset", d, 32'h1);
      rd_reg(4'h7, d);
      chk("mode reset", d, 32'h20);
      rd_reg(4'hf, d);
      chk("unmapped", d, 32'h0);
      for (int i = 0; i < 5; i++) begin
         wr_reg(sat_a[i], sat_w[i]);
         rd_reg(sat_a[i], d);
         chk("speed limit", d, sat_e[i]);
      end
      // Rear-end sensor mode, third index, offset of five pulses
      setup(32'h120, 32'h3, 32'h5, 16'h28, 16'h3c, 16'hff38, 16'hc8);
      go();
      chk("rear home pos", {16'h0, hpos}, 32'h60);
      chk("rear slow", {19'h0, hspd}, 32'h14);
      chk("rear fast", {19'h0, fspd}, 32'h64);
      chk("rear dir", {31'h0, fdir}, 32'h0);
      chk("offset end", {16'h0, pos}, 32'h65);
      rd_reg(4'h1, d);
      chk("done bit", {29'h0, d[2:0]}, 32'h2);
      chk("ramps", {8'h0, cmd.accel, cmd.decel}, 32'h32032);
      // Rear-end mode reversing at the limit ahead, home sensor behind start
      setup(32'h20, 32'h1, 32'h0, 16'hffd8, 16'hffec, 16'hff38, 16'h32);
      go();
      chk("reversal home pos", {16'h0, hpos}, 32'hfff0);
      // Limit-plus-index mode, first index, no offset
      setup(32'h30, 32'h1, 32'h0, 16'h28, 16'h3c, 16'hff9c, 16'hc8);
      go();
      chk("limit home pos", {16'h0, hpos}, 32'hffa0);
      chk("limit fast dir", {31'h0, fdir}, 32'h1);
      chk("limit fast", {19'h0, fspd}, 32'h64);
      chk("limit slow", {19'h0, hspd}, 32'h14);
      chk("limit home dir", {31'h0, hdir}, 32'h0);
      chk("no offset", {16'h0, pos}, 32'hffa0);
      // Limit-plus-index mode in the negative homing direction
      setup(32'h31, 32'h1, 32'h0, 16'h28, 16'h3c, 16'hff38, 16'h64);
      go();
      chk("neg home pos", {16'h0, hpos}, 32'h60);
      chk("neg dirs", {30'h0, fdir, hdir}, 32'h1);
      // Over-travel faults during homing
      for (int i = 0; i < 3; i++) begin
         setup(32'h20, 32'h3, 32'h0, f_hl[i], f_hl[i] + 16'h14, f_ll[i], f_lh[i]);
         go();
         chk("fault alarm", {31'h0, alarm}, 32'h1);
         chk("fault pos", {16'h0, pos}, {16'h0, f_pe[i]});
         rd_reg(4'ha, d);
         chk("fault code", d, 32'h44);
      end
      // Zero settings trip, stop kind follows the over-travel setting
      for (int i = 0; i < 4; i++) begin
         setup({18'h0, i[1:0], 12'h020}, 32'h1, 32'h0, 16'h28, 16'h3c, 16'hff38, 16'hc8);
         wr_reg(zad[i], 32'h0);
         go();
         chk("zero alarm", {31'h0, alarm}, 32'h1);
         rd_reg(4'ha, d);
         chk("zero code", d, 32'h44);
         chk("stop kind", {30'h0, cmd.run, cmd.quick_stop}, {31'h0, i[0]});
      end
      // Unsupported homing type is refused with its own code
      setup(32'h70, 32'h1, 32'h0, 16'h28, 16'h3c, 16'hff38, 16'hc8);
      go();
      rd_reg(4'ha, d);
      chk("bad type", {alarm, d[30:0]}, 32'h800000ff);
      final_report();
   end
endmodule : test_shs_homing
